/* File: rtl/nv_ctrl.sv */
// Host controller driving a nonvolatile-shadowed SRAM over its async pins.
`include "nv_ctrl_map.svh"
`default_nettype none
module nv_ctrl import nv_ctrl_pkg::*; #(
	parameter int STORE_CYC  = `STORE_CYCLES,
	parameter int RECALL_CYC = `RECALL_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Command port
	input  wire logic        req_i,
	input  wire logic [1:0]  op_i,
	input  wire logic        hw_store_i,
	input  wire logic [14:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output var  logic        busy_o,
	output var  logic        done_o,
	output var  logic [7:0]  rdata_o,
	// Device pins
	output var  logic        cs_n_o,
	output var  logic        oe_n_o,
	output var  logic        we_n_o,
	output var  logic [14:0] addr_o,
	input  wire logic [7:0]  dq_i,
	output var  logic [7:0]  dq_o,
	output var  logic        dq_oe_o,
	input  wire logic        sb_i,
	output var  logic        sb_o,
	output var  logic        sb_oe_o
);
	function automatic logic [14:0] key_addr(input logic [2:0] i, input logic rec);
		case (i)
			3'h0: key_addr = `KEY0;
			3'h1: key_addr = `KEY1;
			3'h2: key_addr = `KEY2;
			3'h3: key_addr = `KEY3;
			3'h4: key_addr = `KEY4;
			default: key_addr = rec ? `KEY_RECALL : `KEY_STORE;
		endcase
	endfunction : key_addr

	nv_pin_if pif ();
	state_e st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [2:0]  key_r, key_nxt;
	logic [1:0]  op_r, op_nxt;
	logic [14:0] a_r, a_nxt;
	logic [7:0]  wd_r, wd_nxt, rd_nxt;
	logic        done_nxt, busy_nxt;

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = (cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0;
		key_nxt  = key_r;
		op_nxt   = op_r;
		a_nxt    = a_r;
		wd_nxt   = wd_r;
		rd_nxt   = rdata_o;
		done_nxt = 1'b0;
		busy_nxt = (st_r != S_IDLE);
		pif.cs_n = 1'b1;
		pif.oe_n = 1'b1;
		pif.we_n = 1'b1;
		pif.addr = a_r;
		pif.dout = wd_r;
		pif.dq_oe = 1'b0;
		pif.sb_low = 1'b0;
		case (st_r)
			S_IDLE: begin
				// A low busy pin means a store is running; no access starts.
				if (!sb_i) begin
					st_nxt = S_HW_WAIT;
				end else if (hw_store_i) begin
					st_nxt  = S_HW_LOW;
					cnt_nxt = 32'(`HW_PULSE_CYCLES);
					busy_nxt = 1'b1;
				end else if (req_i) begin
					op_nxt  = op_i;
					a_nxt   = addr_i;
					wd_nxt  = wdata_i;
					key_nxt = 3'h0;
					st_nxt  = S_ACT;
					cnt_nxt = 32'(`CYC_CYCLES);
					busy_nxt = 1'b1;
					// Key sequence addresses: top bit left zero.
					if (op_i == OP_SW_STORE || op_i == OP_SW_RECALL) begin
						a_nxt = key_addr(3'h0, op_i == OP_SW_RECALL);
					end
				end
			end
			S_ACT: begin
				pif.cs_n = 1'b0;
				case (op_r)
					OP_WRITE: begin
						pif.we_n  = 1'b0;
						pif.oe_n  = 1'b1;
						pif.dq_oe = 1'b1;
					end
					OP_READ: pif.oe_n = 1'b0;
					default: pif.oe_n = 1'b1;
				endcase
				if (cnt_r == 32'h1) begin
					if (op_r == OP_READ) begin
						rd_nxt = dq_i;
					end
					st_nxt  = S_GAP;
					cnt_nxt = 32'(`CYC_CYCLES);
				end
			end
			S_GAP: begin
				// Chip select rises between key reads so each one is select-clocked.
				if (cnt_r == 32'h1) begin
					if ((op_r == OP_SW_STORE || op_r == OP_SW_RECALL) && key_r != 3'h5) begin
						key_nxt = key_r + 3'h1;
						a_nxt   = key_addr(key_r + 3'h1, op_r == OP_SW_RECALL);
						st_nxt  = S_ACT;
						cnt_nxt = 32'(`CYC_CYCLES);
					end else if (op_r == OP_SW_STORE) begin
						st_nxt  = S_WAIT_NV;
						cnt_nxt = 32'(STORE_CYC);
					end else if (op_r == OP_SW_RECALL) begin
						st_nxt  = S_WAIT_NV;
						cnt_nxt = 32'(RECALL_CYC);
					end else begin
						st_nxt   = S_IDLE;
						done_nxt = 1'b1;
					end
				end
			end
			S_WAIT_NV: begin
				// Data pins stay released through the whole nonvolatile cycle.
				if (cnt_r == 32'h1) begin
					st_nxt   = S_IDLE;
					done_nxt = 1'b1;
				end
			end
			S_HW_LOW: begin
				pif.sb_low = 1'b1;
				if (cnt_r == 32'h1) begin
					st_nxt  = S_HW_WAIT;
					cnt_nxt = 32'(STORE_CYC);
				end
			end
			S_HW_WAIT: begin
				// Pin may stay high if no write was pending or below threshold.
				if (sb_i && cnt_r <= 32'h1) begin
					st_nxt   = S_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Wait out a possible power-up recall before first access.
			st_r    <= S_WAIT_NV;
			cnt_r   <= 32'(RECALL_CYC);
			key_r   <= 3'h0;
			op_r    <= 2'h0;
			a_r     <= 15'h0000;
			wd_r    <= 8'h00;
			rdata_o <= 8'h00;
			done_o  <= 1'b0;
			busy_o  <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			key_r   <= key_nxt;
			op_r    <= op_nxt;
			a_r     <= a_nxt;
			wd_r    <= wd_nxt;
			rdata_o <= rd_nxt;
			done_o  <= done_nxt;
			busy_o  <= busy_nxt;
		end
	end

	nv_pin_drv u_drv (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.p       (pif),
		.cs_n_o  (cs_n_o),
		.oe_n_o  (oe_n_o),
		.we_n_o  (we_n_o),
		.addr_o  (addr_o),
		.dq_o    (dq_o),
		.dq_oe_o (dq_oe_o),
		.sb_o    (sb_o),
		.sb_oe_o (sb_oe_o)
	);

	chk_write_oe_high: assert property (@(posedge clk_i) disable iff (rst_i)
		!we_n_o |-> oe_n_o) else $error("output enable low during write");
	chk_key_we_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == S_ACT && op_r[1]) |=> we_n_o) else $error("strobe low in key read");
	chk_key_addr_top: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == S_ACT && op_r[1]) |-> !a_r[14]) else $error("key address top bit set");
	chk_no_write_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == S_IDLE && !sb_i) |=> st_r != S_ACT) else $error("access while busy");
	chk_dq_off_nv: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == S_WAIT_NV) |=> !dq_oe_o && cs_n_o) else $error("pins driven in nv cycle");
	chk_hw_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sb_oe_o) |-> sb_oe_o[*2]) else $error("store pulse too short");
	chk_write_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		(!we_n_o && $past(!we_n_o)) |-> $stable(addr_o)) else $error("address moved in write");
	chk_read_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r == S_ACT && op_r == OP_READ) |=> !cs_n_o && !oe_n_o && we_n_o)
		else $error("read pins wrong");
endmodule : nv_ctrl
`default_nettype wire

/* File: rtl/nv_ctrl_map.svh */
// Constants for the nonvolatile SRAM host controller.
`ifndef NV_CTRL_MAP_SVH
`define NV_CTRL_MAP_SVH
`define CLK_PERIOD_NS      10
`define CYC_NS             30
`define CYC_CYCLES         ((`CYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HW_PULSE_NS        20
`define HW_PULSE_CYCLES    ((`HW_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STORE_MS           10
`define STORE_CYCLES       (`STORE_MS * 1000000 / `CLK_PERIOD_NS)
`define RECALL_US          20
`define RECALL_CYCLES      (`RECALL_US * 1000 / `CLK_PERIOD_NS)
`define KEY0               15'h0e38
`define KEY1               15'h31c7
`define KEY2               15'h03e0
`define KEY3               15'h3c1f
`define KEY4               15'h303f
`define KEY_STORE          15'h0fc0
`define KEY_RECALL         15'h0c63
`endif

/* File: rtl/nv_ctrl_pkg.sv */
// Types for the nonvolatile SRAM host controller.
`default_nettype none
package nv_ctrl_pkg;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL} op_e;
	typedef enum logic [2:0] {S_IDLE, S_ACT, S_GAP, S_WAIT_NV, S_HW_LOW, S_HW_WAIT} state_e;
endpackage : nv_ctrl_pkg
`default_nettype wire

/* File: rtl/nv_pin_drv.sv */
// Registered pin stage so every pin comes straight from a flip-flop.
`default_nettype none
module nv_pin_drv (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// From sequencer
	nv_pin_if.drv            p,
	// Pins
	output var  logic        cs_n_o,
	output var  logic        oe_n_o,
	output var  logic        we_n_o,
	output var  logic [14:0] addr_o,
	output var  logic [7:0]  dq_o,
	output var  logic        dq_oe_o,
	output var  logic        sb_o,
	output var  logic        sb_oe_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_n_o  <= 1'b1;
			oe_n_o  <= 1'b1;
			we_n_o  <= 1'b1;
			addr_o  <= 15'h0000;
			dq_o    <= 8'h00;
			dq_oe_o <= 1'b0;
			sb_oe_o <= 1'b0;
		end else begin
			cs_n_o  <= p.cs_n;
			oe_n_o  <= p.oe_n;
			we_n_o  <= p.we_n;
			addr_o  <= p.addr;
			dq_o    <= p.dout;
			dq_oe_o <= p.dq_oe;
			sb_oe_o <= p.sb_low;
		end
	end
	// Open-drain: the level driven is always low.
	always_ff @(posedge clk_i) begin
		sb_o <= 1'b0;
	end
endmodule : nv_pin_drv
`default_nettype wire

/* File: rtl/nv_pin_if.sv */
// Pin bundle between the sequencer and the pin driver.
`default_nettype none
interface nv_pin_if;
	logic        cs_n;
	logic        oe_n;
	logic        we_n;
	logic [14:0] addr;
	logic [7:0]  dout;
	logic        dq_oe;
	logic        sb_low;
	modport seq (output cs_n, oe_n, we_n, addr, dout, dq_oe, sb_low);
	modport drv (input cs_n, oe_n, we_n, addr, dout, dq_oe, sb_low);
endinterface : nv_pin_if
`default_nettype wire

/* File: sim/nv_ctrl_bench.sv */
// Self-checking bench for the nonvolatile SRAM host controller.
`default_nettype none
module nv_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        req_i = 1'b0;
	logic        hw_store_i = 1'b0;
	logic [1:0]  op_i = 2'h0;
	logic [14:0] addr_i = 15'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        busy_o, done_o, cs_n_o, oe_n_o, we_n_o, dq_oe_o, sb_o, sb_oe_o, sb_low;
	logic [7:0]  rdata_o, dq_o, dq_dev;
	logic [14:0] addr_o;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          sb_dev_low = 0;
	logic [7:0]  ref_mem [logic [14:0]];
	wire  logic  sb_i = !((sb_oe_o && !sb_o) || sb_low);
	nv_ctrl #(.STORE_CYC(50), .RECALL_CYC(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.req_i(req_i), .op_i(op_i), .hw_store_i(hw_store_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
		.cs_n_o(cs_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_i(dq_dev),
		.dq_o(dq_o), .dq_oe_o(dq_oe_o), .sb_i(sb_i), .sb_o(sb_o), .sb_oe_o(sb_oe_o));
	nv_dev_model m (.cs_n_i(cs_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o),
		.dq_i(dq_o), .dq_oe_i(dq_oe_o), .sb_i(sb_i), .dq_o(dq_dev), .sb_low_o(sb_low));
	always #5 clk_i = ~clk_i;
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cycles++;
		if (sb_i === 1'b0 && sb_oe_o === 1'b0) sb_dev_low++;
		if (cycles == 60000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// A wait that runs out of cycles means a hang; it must never reach the pass verdict.
	task automatic give_up(input int i);
		if (i >= 9000) begin
			n_errors++;
			final_report();
		end
	endtask : give_up
	function automatic logic [7:0] expect_byte(input logic [14:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
	endfunction : expect_byte
	// The supply event is raised between clock edges so it never races the sampling edge.
	task automatic supply_event(input int n);
		int i;
		@(negedge clk_i);
		m.supply_drop();
		for (i = 0; done_o !== 1'b1 && i < 9000; i++) @(posedge clk_i);
		give_up(i);
		check(m.n_store, n);
	endtask : supply_event
	task automatic run_op(input logic [1:0] k, input logic [14:0] a, input logic [7:0] d,
		input logic hw);
		int i;
		for (i = 0; busy_o !== 1'b0 && i < 9000; i++) @(posedge clk_i);
		give_up(i);
		@(posedge clk_i);
		req_i <= !hw;
		hw_store_i <= hw;
		op_i <= k;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		req_i <= 1'b0;
		hw_store_i <= 1'b0;
		for (i = 0; done_o !== 1'b1 && i < 9000; i++) @(posedge clk_i);
		give_up(i);
	endtask : run_op
	initial begin
		int i;
		logic [14:0] a;
		logic [7:0] d;
		void'($urandom(36475));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 12; i++) begin
			a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : 15'($urandom());
			d = 8'($urandom());
			ref_mem[a] = d;
			run_op(2'h1, a, d, 1'b0);
		end
		foreach (ref_mem[k]) begin
			run_op(2'h0, k, 8'h00, 1'b0);
			check(32'(rdata_o), 32'(expect_byte(k)));
		end
		run_op(2'h1, 15'h1234, 8'ha5, 1'b0);
		run_op(2'h2, 15'h0000, 8'h00, 1'b0);
		check(m.n_store, 1);
		check(32'(sb_dev_low > 0), 1);
		run_op(2'h2, 15'h0000, 8'h00, 1'b0);
		check(m.n_store, 2);
		run_op(2'h1, 15'h1234, 8'h3c, 1'b0);
		run_op(2'h3, 15'h0000, 8'h00, 1'b0);
		check(m.n_recall, 2);
		run_op(2'h0, 15'h1234, 8'h00, 1'b0);
		check(32'(rdata_o), 32'ha5);
		run_op(2'h0, 15'h0000, 8'h00, 1'b1);
		check(m.n_store, 2);
		run_op(2'h1, 15'h1234, 8'h5a, 1'b0);
		run_op(2'h0, 15'h0000, 8'h00, 1'b1);
		check(m.n_store, 3);
		run_op(2'h0, 15'h1234, 8'h00, 1'b0);
		check(32'(rdata_o), 32'h5a);
		supply_event(3);
		run_op(2'h1, 15'h0abc, 8'h77, 1'b0);
		supply_event(4);
		run_op(2'h0, 15'h0abc, 8'h00, 1'b0);
		check(32'(rdata_o), 32'h77);
		final_report();
	end
endmodule : nv_ctrl_bench
`default_nettype wire

/* File: sim/nv_dev_model.sv */
// Behavioural model of the nonvolatile-shadowed SRAM on the far side.
`include "nv_ctrl_map.svh"
`default_nettype none
module nv_dev_model #(
	parameter int STORE_NS             = 300,
	parameter int RECALL_NS            = 150,
	parameter int DROP_PULSE_NS        = 1000,
	parameter bit MAIN_SUPPLY_GROUNDED = 1'b0
) (
	// Host strobes and address
	input  wire logic        cs_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [14:0] addr_i,
	// Data and store/busy
	input  wire logic [7:0]  dq_i,
	input  wire logic        dq_oe_i,
	input  wire logic        sb_i,
	output var  logic [7:0]  dq_o,
	output var  logic        sb_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [32768];
	logic [7:0]  nv [32768];
	logic [14:0] keys [5] = '{`KEY0, `KEY1, `KEY2, `KEY3, `KEY4};
	logic [14:0] a_l;
	logic [7:0]  d_l;
	logic        busy = 1'b1;
	logic        dirty = 1'b0;
	int          idx = 0;
	int          n_store = 0;
	int          n_recall = 0;
	logic        cap_above_switch = 1'b1;
	wire  logic  rd = !cs_n_i && we_n_i && sb_i && !busy;
	wire  logic  wr = !cs_n_i && !we_n_i && sb_i && !busy;
	// A released bus shows the inverse so a stale value never looks valid.
	assign dq_o = (rd && !oe_n_i) ? mem[addr_i] : ~mem[addr_i];
	always @* begin
		if (rd || wr) a_l = addr_i;
		if (wr && dq_oe_i) d_l = dq_i;
	end
	task automatic do_store(input logic hw);
		busy = 1'b1;
		sb_low_o = 1'b1;
		#(STORE_NS);
		nv = mem;
		dirty = 1'b0;
		n_store++;
		sb_low_o = 1'b0;
		if (hw) wait (sb_i);
		busy = 1'b0;
	endtask : do_store
	task automatic do_recall;
		busy = 1'b1;
		foreach (mem[i]) mem[i] = 8'h00;
		#(RECALL_NS);
		mem = nv;
		dirty = 1'b0;
		n_recall++;
		busy = 1'b0;
	endtask : do_recall
	// A backup supply falling through the switch threshold pulls the busy pin low for a
	// fixed pulse; the store follows only if something was written since the last cycle.
	task automatic supply_drop;
		if (!MAIN_SUPPLY_GROUNDED) begin
			cap_above_switch = 1'b0;
			sb_low_o = 1'b1;
			#(DROP_PULSE_NS);
			if (dirty) do_store(1'b0);
			else sb_low_o = 1'b0;
			cap_above_switch = 1'b1;
		end
	endtask : supply_drop
	initial begin
		sb_low_o = 1'b0;
		foreach (nv[i]) nv[i] = 8'h00;
		do_recall();
	end
	always @(negedge wr) begin
		mem[a_l] = d_l;
		dirty = 1'b1;
		idx = 0;
	end
	always @(negedge rd) begin
		if (idx == 5 && a_l[13:0] == `KEY_STORE) begin
			idx = 0;
			do_store(1'b0);
		end else if (idx == 5 && a_l[13:0] == `KEY_RECALL) begin
			idx = 0;
			do_recall();
		end else if (idx < 5 && a_l[13:0] == keys[idx][13:0]) begin
			idx++;
		end else begin
			idx = int'(a_l[13:0] == keys[0][13:0]);
		end
	end
	always @(negedge sb_i) begin
		if (!busy && !sb_low_o && dirty && cap_above_switch) do_store(1'b1);
	end
endmodule : nv_dev_model
`default_nettype wire
